// *** rtl/ssr_pkg.sv ***
// constants for the timing, range and power control bank
package ssr_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] OFS_FILTER = 8'h28;
   localparam logic [7:0] OFS_TIMING = 8'h2B;
   localparam logic [7:0] OFS_RANGE  = 8'h2C;
   localparam logic [7:0] OFS_POWER  = 8'h2D;
   // ==========================================
   // reset values
   localparam logic [7:0] RST_TIMING = 8'h00;
   localparam logic [7:0] RST_RANGE  = 8'h81;
   localparam logic [7:0] RST_POWER  = 8'h01;
   localparam logic [2:0] RST_HPF    = 3'h0;
   // ==========================================
   // field positions
   localparam int BIT_EXTERNAL_CLOCK_SELECT   = 2;
   localparam int BIT_SYNC_HI   = 1;
   localparam int BIT_SYNC_LO   = 0;
   localparam int BIT_HS        = 7;
   localparam int BIT_POL       = 6;
   localparam int BIT_RANGE_HI  = 1;
   localparam int BIT_RANGE_LO  = 0;
   localparam int BIT_RDY_MASK  = 2;
   localparam int BIT_TEMP_OFF  = 1;
   localparam int BIT_STANDBY   = 0;
   localparam int BIT_HPF_HI    = 6;
   localparam int BIT_HPF_LO    = 4;
   // ==========================================
   // sync source codes
   typedef enum logic [1:0] {
      SYNC_INTERNAL = 2'h0,
      SYNC_DIRECT   = 2'h1,
      SYNC_INTERP   = 2'h2,
      SYNC_RESERVED = 2'h3
   } ssr_sync_t;
   // ==========================================
   // interpolation delay in oscillator cycles
   localparam logic [13:0] INTERP_MIN_CYC  = 14'h000E;   // 14
   localparam logic [13:0] INTERP_STEP_CYC = 14'h0333;   // 819
   localparam logic [3:0]  RATE_MAX        = 4'hA;
   localparam logic [13:0] INTERP_MAX_CYC  = 14'h200C;   // 8204
endpackage

// *** rtl/ssr_interp_delay.sv ***
// interpolation delay timer between a sync pulse and sample ready
`timescale 1ns/1ps
module ssr_interp_delay (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic [3:0] rate,
   output logic            done
);
   logic [13:0] cnt_q;
   logic [13:0] target;
   logic [3:0]  rate_c;
   logic        busy_q;

   // delay grows with the rate code, clamped at the top legal code
   always_comb begin
      rate_c = (rate > ssr_pkg::RATE_MAX) ? ssr_pkg::RATE_MAX : rate;
      target = 14'(ssr_pkg::INTERP_MIN_CYC
               + 14'(rate_c * ssr_pkg::INTERP_STEP_CYC));
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         cnt_q  <= 14'h0000;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            busy_q <= 1'b0;
         end else if (start) begin
            busy_q <= 1'b1;
            cnt_q  <= 14'h0001;
         end else if (busy_q) begin
            cnt_q <= cnt_q + 14'h0001;
            if (cnt_q == target - 14'h0001) begin
               busy_q <= 1'b0;
               done   <= 1'b1;
            end
         end
      end
   end

   a_interp_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
      start && !abort |=> !done [*8]) else $error("ready too early");
   // the running count is the helper counter for the long bound
   a_interp_bound: assert property (
      @(posedge core_clk) disable iff (!rstn)
      busy_q |-> cnt_q < ssr_pkg::INTERP_MAX_CYC)
      else $error("ready too late");
endmodule // ssr_interp_delay

// *** rtl/ssr_ctl.sv ***
// timing, range and power control bank with sample ready logic
// What this block does
// - timing bit 2 picks the external clock over the oscillator, reset 0.
// - sync code 00 times internally; 01 flags ready on each locked sync.
// - sync code 10 flags ready 14 to 8204 cycles after sync; 11 reserved.
// - polarity bit 0 makes both irq pins active low, 1 active high.
// - ready mask bit 1 holds the ready pin at 0.
// - temperature disable bit 1 stops temperature processing.
// - standby also stops temperature processing.
// - standby halts both acceleration and temperature paths.
// - entering standby resets digital functions and fifo pointers.
// - high-pass setting may change during measurement and is taken.
// - power bit 0 is standby when 1, measurement when 0, reset 1.
`timescale 1ns/1ps
module ssr_ctl (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic       sync_source_mode_pin,
   input  wire logic       int_sample_tick,
   input  wire logic [3:0] rate_and_lowpass_setting,
   input  wire logic       irq_event_one,
   input  wire logic       irq_event_two,
   output logic            irq_pin_one,
   output logic            irq_pin_two,
   output logic            ready_output_pin,
   output logic            external_clock_select,
   output logic            two_wire_high_speed_select,
   output logic [1:0]      range_sel,
   output logic [2:0]      hpf_corner,
   output logic            accel_run,
   output logic            temp_run,
   output logic            digital_reset,
   output logic            fifo_ptr_clear
);
   // ==========================================
   // registers
   logic [7:0] timing_q;
   logic [7:0] range_q;
   logic [7:0] power_q;
   logic       wr_timing, wr_range, wr_power, wr_filter;
   logic       standby_q_d1;

   // config writes rely on the host being in standby
   assign wr_timing = reg_wr && (reg_addr == ssr_pkg::OFS_TIMING);
   assign wr_range  = reg_wr && (reg_addr == ssr_pkg::OFS_RANGE);
   assign wr_power  = reg_wr && (reg_addr == ssr_pkg::OFS_POWER);
   assign wr_filter = reg_wr && (reg_addr == ssr_pkg::OFS_FILTER);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         timing_q <= ssr_pkg::RST_TIMING;
      end else if (wr_timing) begin
         timing_q <= {5'h00, reg_wdata[ssr_pkg::BIT_EXTERNAL_CLOCK_SELECT:0]};
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         range_q <= ssr_pkg::RST_RANGE;
      end else if (wr_range) begin
         range_q <= {reg_wdata[ssr_pkg::BIT_HS], reg_wdata[ssr_pkg::BIT_POL],
                     4'h0, reg_wdata[ssr_pkg::BIT_RANGE_HI:0]};
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         power_q <= ssr_pkg::RST_POWER;
      end else if (wr_power) begin
         power_q <= {5'h00, reg_wdata[ssr_pkg::BIT_RDY_MASK:0]};
      end
   end

   // high-pass corner accepted in any power state
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hpf_corner <= ssr_pkg::RST_HPF;
      end else if (wr_filter) begin
         hpf_corner <= reg_wdata[ssr_pkg::BIT_HPF_HI:ssr_pkg::BIT_HPF_LO];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ssr_pkg::OFS_TIMING: reg_rdata <= timing_q;
            ssr_pkg::OFS_RANGE:  reg_rdata <= range_q;
            ssr_pkg::OFS_POWER:  reg_rdata <= power_q;
            ssr_pkg::OFS_FILTER: reg_rdata <= {1'b0, hpf_corner, 4'h0};
            default:             reg_rdata <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // decoded controls
   logic            standby;
   logic            ready_mask;
   logic            pol_high;
   ssr_pkg::ssr_sync_t sync_mode;

   assign standby    = power_q[ssr_pkg::BIT_STANDBY];
   assign ready_mask = power_q[ssr_pkg::BIT_RDY_MASK];
   assign pol_high   = range_q[ssr_pkg::BIT_POL];
   assign sync_mode  = ssr_pkg::ssr_sync_t'(
                       timing_q[ssr_pkg::BIT_SYNC_HI:ssr_pkg::BIT_SYNC_LO]);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         external_clock_select      <= 1'b0;
         two_wire_high_speed_select <= ssr_pkg::RST_RANGE[ssr_pkg::BIT_HS];
         range_sel                  <= ssr_pkg::RST_RANGE[
                                       ssr_pkg::BIT_RANGE_HI:
                                       ssr_pkg::BIT_RANGE_LO];
         accel_run                  <= 1'b0;
         temp_run                   <= 1'b0;
      end else begin
         external_clock_select      <= timing_q[ssr_pkg::BIT_EXTERNAL_CLOCK_SELECT];
         two_wire_high_speed_select <= range_q[ssr_pkg::BIT_HS];
         range_sel  <= range_q[ssr_pkg::BIT_RANGE_HI:ssr_pkg::BIT_RANGE_LO];
         accel_run  <= !standby;
         temp_run   <= !standby && !power_q[ssr_pkg::BIT_TEMP_OFF];
      end
   end

   // ==========================================
   // standby entry reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         standby_q_d1   <= 1'b1;
         digital_reset  <= 1'b0;
         fifo_ptr_clear <= 1'b0;
      end else begin
         standby_q_d1   <= standby;
         digital_reset  <= standby && !standby_q_d1;
         fifo_ptr_clear <= standby && !standby_q_d1;
      end
   end

   // ==========================================
   // external sync pin
   logic sync_s1_q, sync_s2_q, sync_s3_q, sync_lvl_q, sync_edge;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync_s1_q  <= 1'b0;
         sync_s2_q  <= 1'b0;
         sync_s3_q  <= 1'b0;
         sync_lvl_q <= 1'b0;
      end else begin
         sync_s1_q <= sync_source_mode_pin;
         sync_s2_q <= sync_s1_q;
         sync_s3_q <= sync_s2_q;
         if (sync_s2_q == sync_s3_q) begin
            sync_lvl_q <= sync_s3_q;
         end
      end
   end
   assign sync_edge = (sync_s2_q == sync_s3_q) && sync_s3_q && !sync_lvl_q;

   // ==========================================
   // sample ready generation
   logic locked_q, ready_q, interp_done, interp_abort;

   assign interp_abort = standby || (sync_mode != ssr_pkg::SYNC_INTERP);

   ssr_interp_delay u_delay (
      .core_clk (core_clk),
      .rstn     (rstn),
      .start    (sync_edge && sync_mode == ssr_pkg::SYNC_INTERP),
      .abort    (interp_abort),
      .rate     (rate_and_lowpass_setting),
      .done     (interp_done)
   );

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         locked_q <= 1'b0;
      end else if (standby || sync_mode != ssr_pkg::SYNC_DIRECT) begin
         locked_q <= 1'b0;
      end else if (sync_edge) begin
         locked_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ready_q <= 1'b0;
      end else if (standby) begin
         ready_q <= 1'b0;
      end else begin
         unique case (sync_mode)
            ssr_pkg::SYNC_INTERNAL: ready_q <= int_sample_tick;
            ssr_pkg::SYNC_DIRECT:   ready_q <= sync_edge && locked_q;
            ssr_pkg::SYNC_INTERP:   ready_q <= interp_done;
            ssr_pkg::SYNC_RESERVED: ready_q <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ready_output_pin <= 1'b0;
         irq_pin_one      <= 1'b1;
         irq_pin_two      <= 1'b1;
      end else begin
         ready_output_pin <= ready_q && !ready_mask;
         irq_pin_one      <= pol_high ? irq_event_one : !irq_event_one;
         irq_pin_two      <= pol_high ? irq_event_two : !irq_event_two;
      end
   end

   // ==========================================
   // checks
   a_ready_masked: assert property (
      @(posedge core_clk) disable iff (!rstn)
      ready_mask |=> !ready_output_pin) else $error("ready not masked");
   a_temp_halted: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (power_q[ssr_pkg::BIT_TEMP_OFF] || standby) |=> !temp_run)
      else $error("temperature still running");
   a_accel_halted: assert property (
      @(posedge core_clk) disable iff (!rstn)
      standby |=> !accel_run && !ready_output_pin)
      else $error("accel path running in standby");
   a_standby_reset: assert property (
      @(posedge core_clk) disable iff (!rstn)
      $rose(standby) |=> digital_reset && fifo_ptr_clear)
      else $error("no reset on standby entry");
   a_irq_polarity: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !pol_high && irq_event_one |=> !irq_pin_one)
      else $error("irq one wrong polarity");
   a_sync_direct: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !standby && sync_mode == ssr_pkg::SYNC_DIRECT && locked_q && sync_edge
      && !ready_mask ##1 !standby && !ready_mask |=> ready_output_pin)
      else $error("sync pulse missed");
   a_sync_reserved: assert property (
      @(posedge core_clk) disable iff (!rstn)
      sync_mode == ssr_pkg::SYNC_RESERVED |=> !ready_q)
      else $error("ready in reserved mode");
   a_range_follow: assert property (
      @(posedge core_clk) disable iff (!rstn)
      wr_range ##2 !wr_range |-> range_sel ==
      $past(reg_wdata[ssr_pkg::BIT_RANGE_HI:ssr_pkg::BIT_RANGE_LO], 2)
      && two_wire_high_speed_select == $past(reg_wdata[ssr_pkg::BIT_HS], 2))
      else $error("range write not applied");
endmodule // ssr_ctl

// *** testbench/ssr_host_model.sv ***
// host controller model on the register strobe port
`timescale 1ns/1ps
module ssr_host_model (
   input  wire logic       core_clk,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end
   // idle bus shows a changed pattern, never the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      @(negedge core_clk);
      q = reg_rdata;
   endtask
endmodule // ssr_host_model

// *** testbench/tb_top.sv ***
// self-checking bench for the timing, range and power bank
`timescale 1ns/1ps
module tb_top;
   logic       core_clk = 1'b0;
   logic       rstn     = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q, v;
   logic       reg_wr, reg_rd, irq1, irq2, rdy, eclk, hs, arun, trun;
   logic       drst, fclr;
   logic       sync_pin = 1'b0;
   logic       tick     = 1'b0;
   logic       ev1      = 1'b0;
   logic       ev2      = 1'b0;
   logic [3:0] rate     = 4'h0;
   logic [1:0] rsel;
   logic [2:0] hpf;
   int         fails = 0, n_compared = 0, seed = 84, c, d;
   int         k_rdy, k_rst, k_clr;
   logic [7:0] ra [4] = '{8'h2B, 8'h2C, 8'h2D, 8'h30};
   logic [7:0] rv [4] = '{8'h00, 8'h81, 8'h01, 8'h00};
   int         rates [3] = '{0, 1, 10};
   always #2 core_clk = ~core_clk;
   ssr_host_model h (.core_clk(core_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   ssr_ctl dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sync_source_mode_pin(sync_pin),
      .int_sample_tick(tick), .rate_and_lowpass_setting(rate),
      .irq_event_one(ev1), .irq_event_two(ev2), .irq_pin_one(irq1),
      .irq_pin_two(irq2), .ready_output_pin(rdy),
      .external_clock_select(eclk), .two_wire_high_speed_select(hs),
      .range_sel(rsel), .hpf_corner(hpf), .accel_run(arun),
      .temp_run(trun), .digital_reset(drst), .fifo_ptr_clear(fclr));

   // three pin flops, ready flop, pin flop
   localparam int SYNC_LAT = 5;

   // ==========================================
   // pulse counters, sampled where outputs are settled
   always @(negedge core_clk) begin
      if (rdy === 1'b1) k_rdy++;
      if (drst === 1'b1) k_rst++;
      if (fclr === 1'b1) k_clr++;
   end

   // ==========================================
   // expectations and checks
   function automatic logic [7:0] exp_range(input logic [7:0] w);
      return {w[7], w[6], 4'h0, w[1:0]};
   endfunction
   function automatic int exp_delay(input int r);
      return int'(ssr_pkg::INTERP_MIN_CYC)
         + int'(ssr_pkg::INTERP_STEP_CYC) * r + SYNC_LAT;
   endfunction
   task automatic chk_val(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_cnt(input string nm, input int e, input int g);
      n_compared++;
      if (g != e) begin
         fails++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic report_and_stop;
      if (fails == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ==========================================
   // stimulus helpers, all called on a falling edge
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic sync_pulse;
      sync_pin = 1'b1;
      idle(6);
      sync_pin = 1'b0;
      idle(6);
   endtask
   task automatic tick_pulse;
      tick = 1'b1;
      idle(1);
      tick = 1'b0;
      idle(4);
   endtask
   task automatic set_power(input logic [7:0] p);
      h.wr(ssr_pkg::OFS_POWER, p);
      idle(2);
   endtask
   task automatic set_mode(input logic [7:0] t);
      set_power(8'h01);
      h.wr(ssr_pkg::OFS_TIMING, t);
      set_power(8'h00);
   endtask

   // ==========================================
   // scenarios
   initial begin
      repeat (20) @(negedge core_clk);
      rstn = 1'b1;
      for (c = 0; c < 4; c++) begin
         h.rd(ra[c], q);
         chk_val("reset value", rv[c], q);
      end
      chk_val("reset pins", 8'h14, {2'h0, eclk, hs, rsel, arun, trun});
      // random configuration, written only in standby
      for (c = 0; c < 16; c++) begin
         v = 8'($random(seed));
         h.wr(ssr_pkg::OFS_RANGE, v);
         h.wr(ssr_pkg::OFS_TIMING, ~v);
         ev1 = v[3];
         ev2 = v[4];
         idle(2);
         h.rd(ssr_pkg::OFS_RANGE, q);
         chk_val("range reg", exp_range(v), q);
         h.rd(ssr_pkg::OFS_TIMING, q);
         chk_val("timing reg", {5'h00, ~v[2:0]}, q);
         chk_val("range pins", {5'h00, v[7], v[1:0]}, {5'h00, hs, rsel});
         chk_val("ext clock pin", {7'h00, ~v[2]}, {7'h00, eclk});
         chk_val("irq pins", {6'h00, ~v[6] ^ v[4], ~v[6] ^ v[3]},
                 {6'h00, irq2, irq1});
      end
      // power states
      h.wr(ssr_pkg::OFS_RANGE, 8'h41);
      h.wr(ssr_pkg::OFS_TIMING, 8'h00);
      set_power(8'h00);
      chk_val("run measure", 8'h03, {6'h00, arun, trun});
      set_power(8'h02);
      chk_val("temp off", 8'h02, {6'h00, arun, trun});
      d = k_rst;
      set_power(8'h01);
      chk_val("run standby", 8'h00, {6'h00, arun, trun});
      chk_cnt("standby reset", d + 1, k_rst);
      chk_cnt("fifo clear", d + 1, k_clr);
      // filter setting taken while measuring
      set_power(8'h00);
      h.wr(ssr_pkg::OFS_FILTER, 8'h5F);
      h.rd(ssr_pkg::OFS_FILTER, q);
      chk_val("filter reg", 8'h50, q);
      chk_val("hpf pins", 8'h05, {5'h00, hpf});
      // internal timing, then masked
      d = k_rdy;
      tick_pulse;
      chk_cnt("ready internal", d + 1, k_rdy);
      set_power(8'h04);
      d = k_rdy;
      tick_pulse;
      chk_cnt("ready masked", d, k_rdy);
      // direct sync: first pulse locks
      set_mode(8'h01);
      d = k_rdy;
      repeat (3) sync_pulse;
      chk_cnt("ready direct", d + 2, k_rdy);
      // reserved code gives no ready
      set_mode(8'h03);
      d = k_rdy;
      sync_pulse;
      tick_pulse;
      chk_cnt("ready reserved", d, k_rdy);
      // interpolated sync at low, next and top rate
      set_mode(8'h02);
      for (c = 0; c < 3; c++) begin
         rate = 4'(rates[c]);
         idle(2);
         sync_pin = 1'b1;
         d = 0;
         while (rdy !== 1'b1 && d < 9000) begin
            @(negedge core_clk);
            d++;
         end
         if (d >= 9000) begin
            fails++;
            report_and_stop;
         end
         chk_cnt("interp delay", exp_delay(rates[c]), d);
         sync_pin = 1'b0;
         idle(6);
      end
      // reset again in mid-run
      rstn = 1'b0;
      idle(3);
      rstn = 1'b1;
      h.rd(ssr_pkg::OFS_POWER, q);
      chk_val("power after reset", 8'h01, q);
      h.rd(ssr_pkg::OFS_TIMING, q);
      chk_val("timing after reset", 8'h00, q);
      report_and_stop;
   end
endmodule // tb_top
